// [src/dmc_pkg.sv]
// shared constants and types of the loop-mode and clock-change link
package dmc_pkg;

	// ----------------------------------------------------------------
	// mode register words and field positions
	// ----------------------------------------------------------------
	localparam int MRW = 13;
	localparam logic [1:0] MR0_SEL = 2'h0;
	localparam logic [1:0] MR1_SEL = 2'h1;
	localparam logic [1:0] MR2_SEL = 2'h2;
	localparam logic [MRW-1:0] MR_RESET = 13'h0000;
	localparam int LOOP_DIS_BIT = 0;
	localparam int LOOP_RST_BIT = 8;
	localparam int CL_LSB = 4;
	localparam int CWL_LSB = 3;
	localparam int AL_LSB = 3;
	localparam logic [MRW-1:0] NOM_TERM_MASK = 13'h0244;
	localparam logic [MRW-1:0] WR_TERM_MASK = 13'h0600;
	localparam logic [3:0] LOOP_OFF_LAT = 4'h6;
	localparam logic [1:0] AL_MINUS1 = 2'h1;
	localparam logic [1:0] AL_MINUS2 = 2'h2;

	// ----------------------------------------------------------------
	// timing, counted in link clock rising edges; half periods and internal refresh in system clocks
	// ----------------------------------------------------------------
	localparam logic [11:0] T_MRD_CK = 12'h004;
	localparam logic [11:0] T_MOD_CK = 12'h00c;
	localparam logic [11:0] T_CKSRE_CK = 12'h005;
	localparam logic [11:0] T_CKSRX_CK = 12'h005;
	localparam logic [11:0] T_XS_CK = 12'h040;
	localparam logic [11:0] T_XP_CK = 12'h003;
	localparam logic [11:0] T_DLLK_CK = 12'h200;
	localparam logic [11:0] T_LONG_IMPEDANCE_CALIBRATION_CK = 12'h100;
	localparam logic [11:0] VREF_WRITE_CK = 12'h200;
	localparam logic [11:0] REFI_CK = 12'h04e;
	localparam logic [11:0] T_MRS_GUARD =
		(T_MRD_CK > T_MOD_CK) ? T_MRD_CK : T_MOD_CK;
	localparam logic [11:0] T_LOCK_WAIT =
		(T_DLLK_CK > T_LONG_IMPEDANCE_CALIBRATION_CK) ? T_DLLK_CK : T_LONG_IMPEDANCE_CALIBRATION_CK;
	// internal refresh interval in system clocks
	localparam logic [11:0] SREF_REFRESH_CLK = 12'h04e;
	localparam logic [3:0] MAX_POSTED = 4'h8;
	localparam logic [3:0] HALF_DEFAULT = 4'h4;
	localparam logic [3:0] HALF_MIN = 4'h4;

	// ----------------------------------------------------------------
	// enumerations
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		CMD_NOP   = 4'h0,
		CMD_MRS   = 4'h1,
		CMD_REF   = 4'h2,
		CMD_SRE   = 4'h3,
		CMD_SRX   = 4'h4,
		CMD_PDE   = 4'h5,
		CMD_PDX   = 4'h6,
		CMD_READ  = 4'h7,
		CMD_WRITE = 4'h8,
		CMD_LONG_IMPEDANCE_CALIBRATION  = 4'h9,
		CMD_FREQ  = 4'ha
	} dmc_cmd_t;

	typedef enum logic [2:0] {
		OP_LOOP_OFF = 3'h0,
		OP_LOOP_ON  = 3'h1,
		OP_PD_FREQ  = 3'h2,
		OP_READ     = 3'h3,
		OP_WRITE    = 3'h4,
		OP_REF      = 3'h5
	} dmc_op_t;

	typedef enum logic [3:0] {
		C_IDLE  = 4'b0001,
		C_ISSUE = 4'b0010,
		C_WAIT  = 4'b0100,
		C_READ  = 4'b1000
	} dmc_cst_t;

	typedef enum logic [2:0] {
		D_IDLE  = 3'b001,
		D_SREF  = 3'b010,
		D_PDOWN = 3'b100
	} dmc_dst_t;

	localparam int ERR_LAT = 0;
	localparam int ERR_TIMING = 1;
	localparam int ERR_LOCK = 2;
	localparam int ERR_POSTED = 3;

endpackage : dmc_pkg

// [src/dmc_link_if.sv]
// link between memory controller end and memory device end
`timescale 1ns/1ps
interface dmc_link_if;
	import dmc_pkg::*;
	logic             ck;
	logic             cke;
	logic             term;
	dmc_cmd_t         cmd;
	logic [1:0]       sel;
	logic [MRW-1:0]   data;
	logic             rd_strobe;
	logic [7:0]       rd_data;

	modport ctrl (output ck, cke, term, cmd, sel, data,
		input rd_strobe, rd_data);
	modport dram (input ck, cke, term, cmd, sel, data,
		output rd_strobe, rd_data);
endinterface : dmc_link_if

// [src/dmc_timer.sv]
// loadable down-counter that steps on a tick
`timescale 1ns/1ps
module dmc_timer #(
	parameter int W = 12
) (
	input  wire logic         clk_i,
	input  wire logic         sys_rst_i,
	input  wire logic         load_i,
	input  wire logic [W-1:0] value_i,
	input  wire logic         tick_i,
	output logic              busy_o,
	output logic              done_o
);
	logic [W-1:0] cnt;

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			cnt <= '0;
		end else if (load_i) begin
			cnt <= value_i;
		end else if (tick_i && cnt != '0) begin
			cnt <= cnt - W'(1);
		end
	end

	assign busy_o = (cnt != '0);
	assign done_o = tick_i && !load_i && (cnt == W'(1));
endmodule : dmc_timer

// [src/dmc_dram.sv]
// memory device end: mode registers, loop mode, power states
`timescale 1ns/1ps
module dmc_dram
	import dmc_pkg::*;
(
	input  wire logic  clk_i,
	input  wire logic  sys_rst_i,
	dmc_link_if.dram   link,
	output logic       in_self_refresh_o,
	output logic       in_power_down_o,
	output logic       loop_disabled_o,
	output logic       loop_locked_o,
	output logic       term_on_o,
	output logic       refresh_pulse_o,
	output logic [3:0] posted_o,
	output logic [3:0] err_o
);
	localparam int SW = 4 + 2 + MRW + 3;

	logic [SW-1:0]  s1;
	logic [SW-1:0]  s2;
	logic           ck_d;
	logic           ck_rise;
	logic           ck_s;
	logic           cke_s;
	logic           term_s;
	dmc_cmd_t       cmd_s;
	logic [3:0]     cmd_raw;
	logic [1:0]     sel_s;
	logic [MRW-1:0] data_s;
	dmc_dst_t       state;
	logic [MRW-1:0] mr0;
	logic [MRW-1:0] mr1;
	logic [MRW-1:0] mr2;
	logic [7:0]     mem [4];
	logic [1:0]     rsel;
	logic [3:0]     cl;
	logic [3:0]     write_latency;
	logic [3:0]     al;
	logic [11:0]    rd_lat;
	logic           loop_dis;
	logic           accept;
	logic           live;
	logic           guard_busy;
	logic           mrd_busy;
	logic           lock_busy;
	logic           rd_done;
	logic [11:0]    refi_cnt;
	logic [11:0]    sref_cnt;

	// ----------------------------------------------------------------
	// input synchronisers and link clock edge
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			s1 <= '0;
			s2 <= '0;
			ck_d <= 1'b0;
		end else begin
			s1 <= {link.ck, link.cke, link.term, link.cmd,
				link.sel, link.data};
			s2 <= s1;
			ck_d <= ck_s;
		end
	end

	assign {ck_s, cke_s, term_s, cmd_raw, sel_s, data_s} = s2;
	assign cmd_s = dmc_cmd_t'(cmd_raw);
	assign ck_rise = ck_s && !ck_d;
	// clock is ignored outside idle
	assign accept = ck_rise && (state == D_IDLE);
	assign live = accept && (cmd_s != CMD_NOP) && (cmd_s != CMD_SRX)
		&& (cmd_s != CMD_PDX) && (cmd_s != CMD_FREQ);

	// ----------------------------------------------------------------
	// mode fields and read latency
	// ----------------------------------------------------------------
	assign loop_dis = mr1[LOOP_DIS_BIT];
	assign cl = mr0[CL_LSB +: 4];
	assign write_latency = mr2[CWL_LSB +: 4];
	assign al = (mr1[AL_LSB +: 2] == AL_MINUS1) ? cl - 4'h1 :
		(mr1[AL_LSB +: 2] == AL_MINUS2) ? cl - 4'h2 : 4'h0;
	// strobe window starts one edge earlier with the loop off
	assign rd_lat = 12'(al) + 12'(cl)
		- (loop_dis ? 12'h001 : 12'h000);

	// ----------------------------------------------------------------
	// power state
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			state <= D_IDLE;
		end else begin
			case (state)
				D_IDLE: begin
					if (accept && cmd_s == CMD_SRE) begin
						state <= D_SREF;
					end else if (accept && cmd_s == CMD_PDE) begin
						state <= D_PDOWN;
					end
				end
				D_SREF: begin
					if (cke_s) begin
						state <= D_IDLE;
					end
				end
				D_PDOWN: begin
					if (cke_s) begin
						state <= D_IDLE;
					end
				end
				default: begin
					state <= D_IDLE;
				end
			endcase
		end
	end

	// internal refresh runs from the system clock only
	always_ff @(posedge clk_i) begin
		if (sys_rst_i || state != D_SREF) begin
			sref_cnt <= 12'h000;
			refresh_pulse_o <= 1'b0;
		end else if (sref_cnt == SREF_REFRESH_CLK) begin
			sref_cnt <= 12'h000;
			refresh_pulse_o <= 1'b1;
		end else begin
			sref_cnt <= sref_cnt + 12'h001;
			refresh_pulse_o <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// mode registers and storage
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			mr0 <= MR_RESET;
			mr1 <= MR_RESET;
			mr2 <= MR_RESET;
		end else if (accept && cmd_s == CMD_MRS) begin
			case (sel_s)
				MR0_SEL: mr0 <= data_s;
				MR1_SEL: mr1 <= data_s;
				MR2_SEL: mr2 <= data_s;
				default: mr0 <= mr0;
			endcase
		end
	end

	// contents untouched by any power state
	always_ff @(posedge clk_i) begin
		if (accept && cmd_s == CMD_WRITE) begin
			mem[sel_s] <= data_s[7:0];
		end
	end

	// ----------------------------------------------------------------
	// timers: mode-set guard, loop lock, read latency
	// ----------------------------------------------------------------
	// a command may land on the edge that ends the delay
	dmc_timer #(.W(12)) u_guard (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.load_i    (accept && cmd_s == CMD_MRS),
		.value_i   (T_MRS_GUARD - 12'h001),
		.tick_i    (ck_rise),
		.busy_o    (guard_busy),
		.done_o    ()
	);

	// mode writes follow each other after the shorter cycle delay
	dmc_timer #(.W(12)) u_mrd (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.load_i    (accept && cmd_s == CMD_MRS),
		.value_i   (T_MRD_CK - 12'h001),
		.tick_i    (ck_rise),
		.busy_o    (mrd_busy),
		.done_o    ()
	);

	dmc_timer #(.W(12)) u_lock (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.load_i    (accept && cmd_s == CMD_MRS && sel_s == MR0_SEL
			&& data_s[LOOP_RST_BIT]),
		.value_i   (T_DLLK_CK),
		.tick_i    (ck_rise),
		.busy_o    (lock_busy),
		.done_o    ()
	);

	dmc_timer #(.W(12)) u_read (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.load_i    (accept && cmd_s == CMD_READ),
		.value_i   (rd_lat),
		.tick_i    (ck_rise),
		.busy_o    (),
		.done_o    (rd_done)
	);

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			rsel <= 2'h0;
			link.rd_strobe <= 1'b0;
			link.rd_data <= 8'h00;
		end else begin
			if (accept && cmd_s == CMD_READ) begin
				rsel <= sel_s;
			end
			if (rd_done) begin
				link.rd_strobe <= ~link.rd_strobe;
				link.rd_data <= mem[rsel];
			end
		end
	end

	// ----------------------------------------------------------------
	// refresh posting and error flags
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			refi_cnt <= 12'h000;
			posted_o <= 4'h0;
		end else if (accept && cmd_s == CMD_REF) begin
			posted_o <= (posted_o != 4'h0) ? posted_o - 4'h1 : 4'h0;
		end else if (accept) begin
			// count frozen in self refresh, kept across it
			if (refi_cnt == REFI_CK) begin
				refi_cnt <= 12'h000;
				if (posted_o != 4'hf) begin
					posted_o <= posted_o + 4'h1;
				end
			end else begin
				refi_cnt <= refi_cnt + 12'h001;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			err_o <= 4'h0;
		end else begin
			if (live && ((cmd_s == CMD_MRS) ? mrd_busy : guard_busy)) begin
				err_o[ERR_TIMING] <= 1'b1;
			end
			if (accept && (cmd_s == CMD_READ || cmd_s == CMD_WRITE)) begin
				if (loop_dis && (cl != LOOP_OFF_LAT
					|| write_latency != LOOP_OFF_LAT)) begin
					err_o[ERR_LAT] <= 1'b1;
				end
				if (!loop_dis && lock_busy) begin
					err_o[ERR_LOCK] <= 1'b1;
				end
			end
			if (posted_o > MAX_POSTED) begin
				err_o[ERR_POSTED] <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// status
	// ----------------------------------------------------------------
	assign in_self_refresh_o = (state == D_SREF);
	assign in_power_down_o = (state == D_PDOWN);
	assign loop_disabled_o = loop_dis;
	assign loop_locked_o = !loop_dis && !lock_busy;
	// no termination with the loop off
	assign term_on_o = term_s && !loop_dis && (state == D_IDLE)
		&& ((mr1 & NOM_TERM_MASK) != MR_RESET);
endmodule : dmc_dram

// [src/dmc_ctrl.sv]
// memory controller end: link clock, loop-mode and clock-change sequences
//
// Notes on behaviour
// - device keeps contents in self refresh unclocked
// - first write waits 512 edges after exit
// - loop disable bit honoured at any time
// - loop off needs read and write latency 6
// - loop off strobe reference one edge earlier
// - realign late read strobes to own clock
// - loop off: termination pin low, fields zero
// - cross clock gap only in self refresh
// - loop off: disable, enter, change, exit, reprogram
// - next command after larger mode delay
// - long impedance calibration ends both switches
// - loop on: enter, change, exit, enable, reset
// - after reset delay program remaining mode registers
// - nothing needing lock before lock time
// - clock period fixed outside frequency changes
// - change clock only in self refresh, power-down
// - device ignores clock after entry hold
// - power-down change: termination off, enable low
// - enable held low during power-down change
// - stable clock before exit, then loop reset
// - termination off through lock after change
// - at most eight refreshes outstanding overall
`timescale 1ns/1ps
module dmc_ctrl
	import dmc_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       sys_rst_i,
	dmc_link_if.ctrl        link,
	input  wire logic       op_valid_i,
	input  wire dmc_op_t    op_i,
	output logic            op_ready_o,
	input  wire logic [3:0] cl_i,
	input  wire logic [3:0] cwl_i,
	input  wire logic [3:0] half_i,
	input  wire logic [1:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       term_en_i,
	output logic            done_o,
	output logic            rd_valid_o,
	output logic [7:0]      rd_data_o,
	output logic            loop_on_o
);
	dmc_cst_t       state;
	dmc_op_t        op;
	logic [2:0]     step;
	logic [3:0]     cl;
	logic [3:0]     write_latency;
	logic [1:0]     addr;
	logic [7:0]     wdata;
	logic [3:0]     half;
	logic [3:0]     half_new;
	logic [3:0]     half_cnt;
	logic           ck_edge;
	logic           ck_fall;
	logic           ck_rise;
	logic [31:0]    cur;
	logic           cur_last;
	dmc_cmd_t       cur_cmd;
	logic [3:0]     cur_cmd_raw;
	logic [1:0]     cur_sel;
	logic [MRW-1:0] cur_data;
	logic [11:0]    cur_wait;
	logic           wait_busy;
	logic           vref_busy;
	logic           stb1;
	logic           stb2;
	logic           stb3;
	logic [7:0]     dat1;
	logic [7:0]     dat2;

	// ----------------------------------------------------------------
	// sequence steps
	// ----------------------------------------------------------------
	function automatic logic [31:0] pk(
		input logic           last,
		input dmc_cmd_t       c,
		input logic [1:0]     s,
		input logic [MRW-1:0] d,
		input logic [11:0]    w
	);
		pk = {last, c, s, d, w};
	endfunction : pk

	function automatic logic [31:0] step_f(
		input dmc_op_t    o,
		input logic [2:0] st,
		input logic [3:0] c_l,
		input logic [3:0] cw_l,
		input logic [1:0] a,
		input logic [7:0] wd
	);
		logic [MRW-1:0] m0_on;
		logic [MRW-1:0] m2_on;
		logic [MRW-1:0] m0_off;
		logic [MRW-1:0] m2_off;
		logic [MRW-1:0] m1_off;
		// termination fields always programmed zero
		m0_on = (MRW'(c_l) << CL_LSB) | (MRW'(1) << LOOP_RST_BIT);
		m2_on = MRW'(cw_l) << CWL_LSB;
		m0_off = MRW'(LOOP_OFF_LAT) << CL_LSB;
		m2_off = MRW'(LOOP_OFF_LAT) << CWL_LSB;
		m1_off = MRW'(1) << LOOP_DIS_BIT;
		step_f = pk(1'b1, CMD_NOP, 2'h0, MR_RESET, 12'h000);
		case (o)
			OP_LOOP_OFF: begin
				case (st)
					3'h0: step_f = pk(1'b0, CMD_MRS, MR1_SEL, m1_off,
						T_MOD_CK);
					3'h1: step_f = pk(1'b0, CMD_SRE, 2'h0, MR_RESET,
						T_CKSRE_CK);
					3'h2: step_f = pk(1'b0, CMD_FREQ, 2'h0, MR_RESET,
						T_CKSRX_CK);
					3'h3: step_f = pk(1'b0, CMD_SRX, 2'h0, MR_RESET,
						T_XS_CK);
					3'h4: step_f = pk(1'b0, CMD_MRS, MR0_SEL, m0_off,
						T_MRD_CK);
					3'h5: step_f = pk(1'b0, CMD_MRS, MR2_SEL, m2_off,
						T_MRS_GUARD);
					default: step_f = pk(1'b1, CMD_LONG_IMPEDANCE_CALIBRATION, 2'h0, MR_RESET,
						T_LONG_IMPEDANCE_CALIBRATION_CK);
				endcase
			end
			OP_LOOP_ON: begin
				case (st)
					3'h0: step_f = pk(1'b0, CMD_SRE, 2'h0, MR_RESET,
						T_CKSRE_CK);
					3'h1: step_f = pk(1'b0, CMD_FREQ, 2'h0, MR_RESET,
						T_CKSRX_CK);
					3'h2: step_f = pk(1'b0, CMD_SRX, 2'h0, MR_RESET,
						T_XS_CK);
					3'h3: step_f = pk(1'b0, CMD_MRS, MR1_SEL, MR_RESET,
						T_MRD_CK);
					3'h4: step_f = pk(1'b0, CMD_MRS, MR0_SEL, m0_on,
						T_MRD_CK);
					3'h5: step_f = pk(1'b0, CMD_MRS, MR2_SEL, m2_on,
						T_MRS_GUARD);
					default: step_f = pk(1'b1, CMD_LONG_IMPEDANCE_CALIBRATION, 2'h0, MR_RESET,
						T_LOCK_WAIT);
				endcase
			end
			OP_PD_FREQ: begin
				case (st)
					3'h0: step_f = pk(1'b0, CMD_PDE, 2'h0, MR_RESET,
						T_CKSRE_CK);
					3'h1: step_f = pk(1'b0, CMD_FREQ, 2'h0, MR_RESET,
						T_CKSRX_CK);
					3'h2: step_f = pk(1'b0, CMD_PDX, 2'h0, MR_RESET,
						T_XP_CK);
					3'h3: step_f = pk(1'b0, CMD_MRS, MR0_SEL, m0_on,
						T_MRD_CK);
					3'h4: step_f = pk(1'b0, CMD_MRS, MR2_SEL, m2_on,
						T_MRS_GUARD);
					default: step_f = pk(1'b1, CMD_NOP, 2'h0, MR_RESET,
						T_DLLK_CK);
				endcase
			end
			OP_READ: step_f = pk(1'b1, CMD_READ, a, MR_RESET, 12'h000);
			OP_WRITE: step_f = pk(1'b1, CMD_WRITE, a,
				{5'h00, wd}, 12'h000);
			OP_REF: step_f = pk(1'b1, CMD_REF, 2'h0, MR_RESET, 12'h001);
			default: step_f = pk(1'b1, CMD_NOP, 2'h0, MR_RESET, 12'h000);
		endcase
	endfunction : step_f

	assign cur = step_f(op, step, cl, write_latency, addr, wdata);
	assign {cur_last, cur_cmd_raw, cur_sel, cur_data, cur_wait} = cur;
	assign cur_cmd = dmc_cmd_t'(cur_cmd_raw);

	// ----------------------------------------------------------------
	// link clock divider
	// ----------------------------------------------------------------
	assign ck_edge = (half_cnt == half - 4'h1);
	assign ck_fall = ck_edge && link.ck;
	assign ck_rise = ck_edge && !link.ck;

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			half_cnt <= 4'h0;
			link.ck <= 1'b0;
		end else if (ck_edge) begin
			half_cnt <= 4'h0;
			link.ck <= ~link.ck;
		end else begin
			half_cnt <= half_cnt + 4'h1;
		end
	end

	// period moves only in the frequency step of a sequence
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			half <= HALF_DEFAULT;
		end else if (state == C_ISSUE && ck_fall
			&& cur_cmd == CMD_FREQ) begin
			half <= half_new;
		end
	end

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	// writes held off until the reference has settled after exit
	assign op_ready_o = (state == C_IDLE)
		&& !(op_i == OP_WRITE && vref_busy);

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			state <= C_IDLE;
			op <= OP_REF;
			step <= 3'h0;
			cl <= LOOP_OFF_LAT;
			write_latency <= LOOP_OFF_LAT;
			addr <= 2'h0;
			wdata <= 8'h00;
			half_new <= HALF_DEFAULT;
			done_o <= 1'b0;
		end else begin
			done_o <= 1'b0;
			case (state)
				C_IDLE: begin
					if (op_valid_i && op_ready_o) begin
						op <= op_i;
						step <= 3'h0;
						cl <= cl_i;
						write_latency <= cwl_i;
						addr <= addr_i;
						wdata <= wdata_i;
						half_new <= (half_i < HALF_MIN) ? HALF_MIN : half_i;
						state <= C_ISSUE;
					end
				end
				C_ISSUE: begin
					if (ck_fall) begin
						state <= (cur_cmd == CMD_READ) ? C_READ : C_WAIT;
					end
				end
				C_WAIT: begin
					if (!wait_busy) begin
						if (cur_last) begin
							done_o <= 1'b1;
							state <= C_IDLE;
						end else begin
							step <= step + 3'h1;
							state <= C_ISSUE;
						end
					end
				end
				C_READ: begin
					if (stb2 != stb3) begin
						done_o <= 1'b1;
						state <= C_IDLE;
					end
				end
				default: begin
					state <= C_IDLE;
				end
			endcase
		end
	end

	dmc_timer #(.W(12)) u_wait (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.load_i    (state == C_ISSUE && ck_fall),
		.value_i   (cur_wait),
		.tick_i    (ck_rise),
		.busy_o    (wait_busy),
		.done_o    ()
	);

	dmc_timer #(.W(12)) u_vref (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.load_i    (state == C_ISSUE && ck_fall && cur_cmd == CMD_SRX),
		.value_i   (VREF_WRITE_CK),
		.tick_i    (ck_rise),
		.busy_o    (vref_busy),
		.done_o    ()
	);

	// ----------------------------------------------------------------
	// link command outputs, changed on the falling link edge
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			link.cmd <= CMD_NOP;
			link.sel <= 2'h0;
			link.data <= MR_RESET;
			link.cke <= 1'b1;
		end else if (ck_fall) begin
			if (state == C_ISSUE && cur_cmd != CMD_FREQ) begin
				link.cmd <= cur_cmd;
				link.sel <= cur_sel;
				link.data <= cur_data;
			end else begin
				link.cmd <= CMD_NOP;
			end
			if (state == C_ISSUE) begin
				if (cur_cmd == CMD_SRE || cur_cmd == CMD_PDE) begin
					link.cke <= 1'b0;
				end else if (cur_cmd == CMD_SRX || cur_cmd == CMD_PDX) begin
					link.cke <= 1'b1;
				end
			end
		end
	end

	// termination only in idle with the loop running
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			loop_on_o <= 1'b1;
			link.term <= 1'b0;
		end else begin
			if (state == C_IDLE && op_valid_i && op_ready_o
				&& op_i == OP_LOOP_OFF) begin
				loop_on_o <= 1'b0;
			end else if (done_o && op == OP_LOOP_ON) begin
				loop_on_o <= 1'b1;
			end
			link.term <= term_en_i && loop_on_o && (state == C_IDLE)
				&& !(op_valid_i && op_i != OP_READ
				&& op_i != OP_WRITE);
		end
	end

	// ----------------------------------------------------------------
	// read strobe realignment
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			stb1 <= 1'b0;
			stb2 <= 1'b0;
			stb3 <= 1'b0;
			dat1 <= 8'h00;
			dat2 <= 8'h00;
			rd_valid_o <= 1'b0;
			rd_data_o <= 8'h00;
		end else begin
			stb1 <= link.rd_strobe;
			stb2 <= stb1;
			stb3 <= stb2;
			dat1 <= link.rd_data;
			dat2 <= dat1;
			rd_valid_o <= 1'b0;
			if (stb2 != stb3) begin
				rd_valid_o <= 1'b1;
				rd_data_o <= dat2;
			end
		end
	end
endmodule : dmc_ctrl

// [verif/dmc_link_chk.sv]
// checker of the link between controller and device ends
`timescale 1ns/1ps
module dmc_link_chk
	import dmc_pkg::*;
(
	input wire logic           clk_i,
	input wire logic           sys_rst_i,
	input wire logic           ck,
	input wire logic           cke,
	input wire logic           term,
	input wire dmc_cmd_t       cmd,
	input wire logic [1:0]     sel,
	input wire logic [MRW-1:0] data,
	input wire logic           rd_strobe
);
	logic       ck_q, rs_q, v, off, pend;
	logic [7:0] h, lh, g, r;
	logic [3:0] cl;
	wire        tog = ck ^ ck_q;
	wire        rise = ck & ~ck_q;
	wire        mrs = rise && cmd == CMD_MRS;
	always_ff @(posedge clk_i) begin
		ck_q <= sys_rst_i ? 1'b0 : ck;
		rs_q <= rd_strobe;
	end
	// half period of the link clock in system clocks
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			h <= 8'h01;
			lh <= 8'h00;
			v <= 1'b0;
		end else if (tog) begin
			h <= 8'h01;
			lh <= v ? h : 8'h00;
			v <= 1'b1;
		end else begin
			h <= h + 8'h01;
		end
	end
	// shadow of loop mode and latency, link edges since a mode write
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			g <= 8'h0f;
			off <= 1'b0;
			cl <= 4'h0;
		end else if (mrs) begin
			g <= 8'h01;
			if (sel == MR1_SEL) off <= data[LOOP_DIS_BIT];
			if (sel == MR0_SEL) cl <= data[CL_LSB+:4];
		end else if (rise && g < 8'h0f) begin
			g <= g + 8'h01;
		end
	end
	always_ff @(posedge clk_i) begin
		if (sys_rst_i || (rise && cmd == CMD_READ)) begin
			pend <= ~sys_rst_i;
			r <= 8'h00;
		end else begin
			if (rise) r <= r + 8'h01;
			if (rd_strobe != rs_q) pend <= 1'b0;
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	chk_term_loop_off: assert property (off |-> !term)
		else $error("termination pin high with loop off");
	chk_nom_term_zero: assert property (mrs && sel == MR1_SEL && data[0]
		|-> (data & NOM_TERM_MASK) == 13'h0000) else $error("nominal term set");
	chk_wr_term_zero: assert property (mrs && sel == MR2_SEL && off
		|-> (data & WR_TERM_MASK) == 13'h0000) else $error("write term set");
	chk_read_lat_six: assert property (mrs && sel == MR0_SEL && off
		|-> data[CL_LSB+:4] == 4'h6) else $error("read latency not 6");
	chk_write_lat_six: assert property (mrs && sel == MR2_SEL && off
		|-> data[CWL_LSB+:4] == 4'h6) else $error("write latency not 6");
	chk_mrs_gap: assert property (mrs |-> g >= 8'h04)
		else $error("mode writes too close");
	chk_cmd_after_mrs: assert property (rise && cmd != CMD_NOP
		&& cmd != CMD_MRS |-> g >= 8'h0c) else $error("command too early");
	chk_ck_steady: assert property (tog && cke && lh != 8'h00
		|-> h == lh) else $error("link clock changed with enable high");
	chk_term_cke_low: assert property (!cke |-> !term)
		else $error("termination pin high with enable low");
	chk_strobe_lat: assert property ($changed(rd_strobe)
		|-> pend && r == {4'h0, cl - {3'h0, off}}) else $error("strobe late");
endmodule : dmc_link_chk

// [verif/dram_dll_mode_and_clock_change_tb.sv]
// self-checking bench joining controller and device ends
`timescale 1ns/1ps
module dram_dll_mode_and_clock_change_tb;
	import dmc_pkg::*;
	logic       clk_i = 0, sys_rst_i = 1, op_valid_i = 0, term_en_i = 1;
	dmc_op_t    op_i = OP_READ;
	logic [3:0] cl_i = 4'h6, cwl_i = 4'h6, half_i = 4'h4;
	logic [1:0] addr_i = 2'h0;
	logic [2:0] seen;
	logic [7:0] wdata_i = 8'h00, rd_data_o;
	logic       op_ready_o, done_o, rd_valid_o, loop_on_o, term_on_o;
	logic       in_self_refresh_o, in_power_down_o, refresh_pulse_o;
	logic       loop_disabled_o, loop_locked_o;
	logic [3:0] err_o;
	int         fail_count = 0, n_tests = 0;
	always #50 clk_i = ~clk_i;
	dmc_link_if lnk ();
	dmc_ctrl dmc_ctrl_inst (.clk_i, .sys_rst_i, .link(lnk), .op_valid_i,
		.op_i, .op_ready_o, .cl_i, .cwl_i, .half_i, .addr_i, .wdata_i,
		.term_en_i, .done_o, .rd_valid_o, .rd_data_o, .loop_on_o);
	dmc_dram dmc_dram_inst (.clk_i, .sys_rst_i, .link(lnk),
		.in_self_refresh_o, .in_power_down_o, .loop_disabled_o,
		.loop_locked_o, .term_on_o, .refresh_pulse_o, .posted_o(), .err_o);
	dmc_link_chk dmc_link_chk_inst (.clk_i, .sys_rst_i, .ck(lnk.ck),
		.cke(lnk.cke), .term(lnk.term), .cmd(lnk.cmd), .sel(lnk.sel),
		.data(lnk.data), .rd_strobe(lnk.rd_strobe));
	task automatic check(input string what, input logic [7:0] got,
		input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : conclude
	task automatic run(input dmc_op_t o, input logic [3:0] hf,
		input logic [1:0] a, input logic [7:0] d);
		int i;
		op_i = o;
		half_i = hf;
		addr_i = a;
		wdata_i = d;
		seen = 3'h0;
		i = 0;
		#1;
		while (op_ready_o !== 1'b1 && i < 9000) begin
			@(negedge clk_i);
			i++;
		end
		op_valid_i = 1'b1;
		@(negedge clk_i);
		op_valid_i = 1'b0;
		while (done_o !== 1'b1 && i < 18000) begin
			@(negedge clk_i);
			seen = seen | {refresh_pulse_o, in_power_down_o,
				in_self_refresh_o};
			i++;
		end
		if (i >= 18000) begin
			fail_count++;
			conclude();
		end
		$display("op %s done", o.name());
	endtask : run
	initial begin
		repeat (8) @(negedge clk_i);
		sys_rst_i = 1'b0;
		check("loop on", 8'(loop_on_o), 8'h01);
		run(OP_WRITE, 4'h4, 2'h1, 8'ha5);
		run(OP_LOOP_OFF, 4'h8, 2'h0, 8'h00);
		check("sref", 8'(seen), 8'h05);
		check("ctrl loop", 8'(loop_on_o), 8'h00);
		check("loop off", 8'(loop_disabled_o), 8'h01);
		check("term", 8'(term_on_o), 8'h00);
		op_i = OP_WRITE;
		#1;
		check("write hold", 8'(op_ready_o), 8'h00);
		run(OP_READ, 4'h8, 2'h1, 8'h00);
		check("data kept", rd_data_o, 8'ha5);
		check("rd valid", 8'(rd_valid_o), 8'h01);
		run(OP_WRITE, 4'h8, 2'h2, 8'h3c);
		run(OP_READ, 4'h8, 2'h2, 8'h00);
		check("rd off", rd_data_o, 8'h3c);
		repeat (9) run(OP_REF, 4'h8, 2'h0, 8'h00);
		cl_i = 4'h7;
		cwl_i = 4'h5;
		run(OP_LOOP_ON, 4'h4, 2'h0, 8'h00);
		check("loop on", 8'(loop_disabled_o), 8'h00);
		check("locked", 8'(loop_locked_o), 8'h01);
		check("sref on", 8'(seen), 8'h05);
		repeat (9) run(OP_REF, 4'h4, 2'h0, 8'h00);
		check("ctrl on", 8'(loop_on_o), 8'h01);
		run(OP_PD_FREQ, 4'h5, 2'h0, 8'h00);
		check("pdown", 8'(seen), 8'h02);
		run(OP_REF, 4'h5, 2'h0, 8'h00);
		run(OP_READ, 4'h5, 2'h1, 8'h00);
		check("rd on", rd_data_o, 8'ha5);
		check("errors", 8'(err_o), 8'h00);
		conclude();
	end
endmodule : dram_dll_mode_and_clock_change_tb
